// [src/irq_enable_bank.v]
// one 8-bit peripheral interrupt enable register with its per-source request gating
`timescale 1ns/1ps
`default_nettype none

module irq_enable_bank #(
  parameter [7:0] IMPL_MASK = 8'hFF,
  parameter [7:0] RST_VALUE = 8'h00
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  input  wire [7:0] src_flags,
  input  wire       group_ok,
  output wire [7:0] enable_q,
  output wire [7:0] pending_q,
  output wire [7:0] req_q
);

  reg [7:0] enable_r;
  reg [7:0] req_r;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      if (IMPL_MASK[i]) begin : g_impl
        always @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            enable_r[i] <= RST_VALUE[i];
            req_r[i]    <= 1'b0;
          end else begin
            if (wr_en) begin
              enable_r[i] <= wr_data[i];
            end
            // flag, own enable and group condition must all hold
            req_r[i] <= src_flags[i] & enable_r[i] & group_ok;
          end
        end
      end else begin : g_unimpl
        // unimplemented bit: writes dropped, reads zero
        always @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            enable_r[i] <= 1'b0;
            req_r[i]    <= 1'b0;
          end else begin
            enable_r[i] <= 1'b0;
            req_r[i]    <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign enable_q  = enable_r;
  assign pending_q = src_flags & enable_r;
  assign req_q     = req_r;

endmodule // irq_enable_bank

`default_nettype wire

// [src/periph_irq_consts.vh]
// register offsets, field positions and reset values of the peripheral interrupt enable bank
`ifndef PERIPH_IRQ_CONSTS_VH
`define PERIPH_IRQ_CONSTS_VH

`define PIRQ_ADDR_W              12
`define PIRQ_OFS_ENABLE_ONE      12'h000
`define PIRQ_OFS_ENABLE_TWO      12'h004
`define PIRQ_OFS_ENABLE_THREE    12'h008
`define PIRQ_OFS_CONTROL         12'h00C
`define PIRQ_OFS_STATUS          12'h010
`define PIRQ_OFS_MASK            12'h014
`define PIRQ_OFS_PENDING         12'h018

`define PIRQ_BIT_TIMER_OVF       0
`define PIRQ_BIT_PERIOD_MATCH    1
`define PIRQ_BIT_CAPCOMP_ONE     2
`define PIRQ_BIT_SYNC_SERIAL     3
`define PIRQ_BIT_SERIAL_TX       4
`define PIRQ_BIT_SERIAL_RX       5
`define PIRQ_BIT_CONVERTER       6
`define PIRQ_BIT_UNIMPL          7

`define PIRQ_CTRL_GROUP_EN_BIT   0
`define PIRQ_CTRL_PRIO_MODE_BIT  1

`define PIRQ_IMPL_ONE            8'h7F
`define PIRQ_IMPL_TWO            8'hFF
`define PIRQ_IMPL_THREE          8'hFF

`define PIRQ_RST_ENABLE          8'h00
`define PIRQ_RST_CONTROL         2'h0
`define PIRQ_RST_STATUS          3'h0
`define PIRQ_RST_MASK            3'h0

`endif

// [src/periph_irq_enable.v]
// peripheral interrupt enable bank: three enable registers, group gating and an APB register slave
//
// Summary of operation
// - With priority mode off, no peripheral request passes unless the peripheral group enable bit is set.
// - The per-source enable bits are split over three separate enable registers.
// - Bit 7 of the first enable register is not implemented, ignores writes and reads as zero.
// - Bit 6 of the first enable register enables the converter completion interrupt.
// - Bit 5 enables the enhanced serial port receive interrupt.
// - Bit 4 enables the enhanced serial port transmit interrupt.
// - Bit 3 enables the master synchronous serial port interrupt.
// - Bit 2 enables the capture/compare unit one interrupt.
// - Bit 1 enables the period timer match interrupt.
// - Bit 0 enables the overflow timer interrupt.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "periph_irq_consts.vh"

module periph_irq_enable (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  src_flags_one,
  input  wire [7:0]  src_flags_two,
  input  wire [7:0]  src_flags_three,
  output reg  [7:0]  periph_req_one,
  output reg  [7:0]  periph_req_two,
  output reg  [7:0]  periph_req_three,
  output reg         periph_irq,
  output reg         irq
);

  // reset release through two flops; assertion stays asynchronous
  reg rst_meta_r;
  reg rst_sync_r;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  wire rst_n;
  assign rst_n = rst_sync_r;

  // apb decode
  wire        access_ph;
  wire        xfer_done;
  wire        aligned;
  wire        hit_en_one;
  wire        hit_en_two;
  wire        hit_en_three;
  wire        hit_ctrl;
  wire        hit_status;
  wire        hit_mask;
  wire        hit_pend;
  wire        hit_any;
  wire        wr_ok;

  assign access_ph    = psel & penable;
  assign xfer_done    = access_ph & pready;
  assign aligned      = (paddr[1:0] == 2'h0);
  assign hit_en_one   = aligned & (paddr == `PIRQ_OFS_ENABLE_ONE);
  assign hit_en_two   = aligned & (paddr == `PIRQ_OFS_ENABLE_TWO);
  assign hit_en_three = aligned & (paddr == `PIRQ_OFS_ENABLE_THREE);
  assign hit_ctrl     = aligned & (paddr == `PIRQ_OFS_CONTROL);
  assign hit_status   = aligned & (paddr == `PIRQ_OFS_STATUS);
  assign hit_mask     = aligned & (paddr == `PIRQ_OFS_MASK);
  assign hit_pend     = aligned & (paddr == `PIRQ_OFS_PENDING);
  assign hit_any      = hit_en_one | hit_en_two | hit_en_three | hit_ctrl
                      | hit_status | hit_mask | hit_pend;
  // only byte lane 0 carries register data; other lanes are ignored
  assign wr_ok        = xfer_done & pwrite & pstrb[0] & hit_any;

  // per-register strobes; the status read strobe is what clears the sticky bits
  wire        wr_en_one;
  wire        wr_en_two;
  wire        wr_en_three;
  wire        wr_ctrl;
  wire        wr_mask;
  wire        rd_status;

  assign wr_en_one    = wr_ok & hit_en_one;
  assign wr_en_two    = wr_ok & hit_en_two;
  assign wr_en_three  = wr_ok & hit_en_three;
  assign wr_ctrl      = wr_ok & hit_ctrl;
  assign wr_mask      = wr_ok & hit_mask;
  assign rd_status    = xfer_done & ~pwrite & hit_status;

  // control register: group enable and priority mode
  reg  [1:0] control_r;
  wire       group_en;
  wire       prio_mode;
  wire       group_ok;

  assign group_en  = control_r[`PIRQ_CTRL_GROUP_EN_BIT];
  assign prio_mode = control_r[`PIRQ_CTRL_PRIO_MODE_BIT];
  // in priority mode the group gate is bypassed; priority logic lives elsewhere
  assign group_ok  = prio_mode | group_en;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_r <= `PIRQ_RST_CONTROL;
    end else if (wr_ctrl) begin
      control_r <= pwdata[1:0];
    end
  end

  // the three enable registers
  wire [7:0] enable_one_q;
  wire [7:0] enable_two_q;
  wire [7:0] enable_three_q;
  wire [7:0] pend_one;
  wire [7:0] pend_two;
  wire [7:0] pend_three;
  wire [7:0] req_one;
  wire [7:0] req_two;
  wire [7:0] req_three;

  // bit 7 dropped; bits 6..0 gate converter, serial rx/tx, sync serial,
  // capcomp one, period match and timer overflow
  irq_enable_bank #(
    .IMPL_MASK (`PIRQ_IMPL_ONE),
    .RST_VALUE (`PIRQ_RST_ENABLE)
  ) u_enable_one (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .wr_en     (wr_en_one),
    .wr_data   (pwdata[7:0]),
    .src_flags (src_flags_one),
    .group_ok  (group_ok),
    .enable_q  (enable_one_q),
    .pending_q (pend_one),
    .req_q     (req_one)
  );

  // further sources need their own registers
  irq_enable_bank #(
    .IMPL_MASK (`PIRQ_IMPL_TWO),
    .RST_VALUE (`PIRQ_RST_ENABLE)
  ) u_enable_two (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .wr_en     (wr_en_two),
    .wr_data   (pwdata[7:0]),
    .src_flags (src_flags_two),
    .group_ok  (group_ok),
    .enable_q  (enable_two_q),
    .pending_q (pend_two),
    .req_q     (req_two)
  );

  irq_enable_bank #(
    .IMPL_MASK (`PIRQ_IMPL_THREE),
    .RST_VALUE (`PIRQ_RST_ENABLE)
  ) u_enable_three (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .wr_en     (wr_en_three),
    .wr_data   (pwdata[7:0]),
    .src_flags (src_flags_three),
    .group_ok  (group_ok),
    .enable_q  (enable_three_q),
    .pending_q (pend_three),
    .req_q     (req_three)
  );

  // group events: rising edge of any gated request of a register
  wire [2:0] group_any;
  reg  [2:0] group_any_d_r;
  wire [2:0] group_rise;

  assign group_any  = {|req_three, |req_two, |req_one};
  assign group_rise = group_any & ~group_any_d_r;

  // sticky status, cleared by read; a set in the clearing cycle wins
  reg  [2:0] status_r;
  reg  [2:0] status_nxt;
  reg  [2:0] mask_r;
  reg  [2:0] mask_nxt;
  reg  [2:0] read_seen_r;

  always @* begin
    status_nxt = status_r;
    if (rd_status) begin
      // clear only what the reader was actually shown
      status_nxt = status_nxt & ~read_seen_r;
    end
    status_nxt = status_nxt | group_rise;
  end

  // irq is built from the next mask, so a mask write acts without a cycle of lag
  always @* begin
    mask_nxt = mask_r;
    if (wr_mask) begin
      mask_nxt = pwdata[2:0];
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      group_any_d_r <= 3'h0;
    end else begin
      group_any_d_r <= group_any;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= `PIRQ_RST_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= `PIRQ_RST_MASK;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // read mux
  reg [31:0] rd_data;

  always @* begin
    rd_data = 32'h0000_0000;
    case (1'b1)
      hit_en_one:   rd_data = {24'h00_0000, enable_one_q};
      hit_en_two:   rd_data = {24'h00_0000, enable_two_q};
      hit_en_three: rd_data = {24'h00_0000, enable_three_q};
      hit_ctrl:     rd_data = {30'h0000_0000, control_r};
      hit_status:   rd_data = {29'h0000_0000, status_r};
      hit_mask:     rd_data = {29'h0000_0000, mask_r};
      // flags are never cleared here; software clears them at the source
      hit_pend:     rd_data = {8'h00, pend_three, pend_two, pend_one};
      default:      rd_data = 32'h0000_0000;
    endcase
  end

  // apb response: one wait state, so every answer comes from flops
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0000_0000;
      read_seen_r <= 3'h0;
    end else begin
      if (access_ph & ~pready) begin
        pready      <= 1'b1;
        pslverr     <= ~hit_any;
        prdata      <= pwrite ? 32'h0000_0000 : rd_data;
        read_seen_r <= status_r;
      end else begin
        pready      <= 1'b0;
        pslverr     <= 1'b0;
        prdata      <= 32'h0000_0000;
        read_seen_r <= 3'h0;
      end
    end
  end

  // registered request outputs
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_req_one   <= 8'h00;
      periph_req_two   <= 8'h00;
      periph_req_three <= 8'h00;
      periph_irq       <= 1'b0;
    end else begin
      periph_req_one   <= req_one;
      periph_req_two   <= req_two;
      periph_req_three <= req_three;
      periph_irq       <= |group_any;
    end
  end

  // summary interrupt: high while an unmasked sticky status bit is set
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_nxt & mask_nxt);
    end
  end

endmodule // periph_irq_enable

`default_nettype wire

// [verification/periph_irq_enable_monitor.sv]
// port assertions of the peripheral interrupt enable bank
`timescale 1ns/1ps
`default_nettype none
module periph_irq_enable_monitor (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  src_flags_one,
  input wire logic [7:0]  periph_req_one,
  input wire logic [7:0]  periph_req_two,
  input wire logic [7:0]  periph_req_three,
  input wire logic        periph_irq
);
  logic [1:0] ctrl_r;
  logic [7:0] en_r;
  // shadow copies rebuilt from the bus, so gating can be judged without internal probes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= 2'h0;
      en_r <= 8'h00;
    end else if (psel && penable && pready && pwrite && pstrb[0]) begin
      if (paddr == 12'h00C) ctrl_r <= pwdata[1:0];
      if (paddr == 12'h000) en_r <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence gate_shut;
    (ctrl_r == 2'h0) [*3];
  endsequence
  sequence conv_armed;
    (ctrl_r[0] && en_r[6] && src_flags_one[6]) [*3];
  endsequence
  AST_GROUP_GATE: assert property (gate_shut |-> !periph_irq)
    else $error("request passed a shut group gate");
  AST_UNIMPL_REQ: assert property (periph_req_one[7] == 1'b0)
    else $error("request on unimplemented bit");
  AST_UNIMPL_READ: assert property (pready && !pwrite && paddr == 12'h000 |-> !prdata[7])
    else $error("unimplemented bit read as one");
  AST_CONV_PASS: assert property (conv_armed |-> periph_req_one[6])
    else $error("enabled converter request blocked");
  AST_REQ_CAUSE: assert property ((periph_req_one & ~($past(src_flags_one, 2) & $past(en_r, 2))) == 8'h00)
    else $error("request without flag and enable");
  AST_IRQ_OR: assert property (periph_irq == (|{periph_req_one, periph_req_two, periph_req_three}))
    else $error("summary request differs from the requests");
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  AST_MISALIGN_ERR: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
endmodule // periph_irq_enable_monitor
`default_nettype wire

// [verification/periph_src_model.sv]
// peripheral request sources: sticky flags set by events, cleared only by software
`timescale 1ns/1ps
`default_nettype none
module periph_src_model (
  input  wire logic        sys_clk,
  input  wire logic [23:0] set_ev,
  input  wire logic [23:0] clr_sw,
  output var  logic [23:0] flags
);
  initial flags = 24'h000000;
  always @(posedge sys_clk) begin
    flags <= (flags & ~clr_sw) | set_ev;
  end
endmodule // periph_src_model
`default_nettype wire

// [verification/peripheral_interrupt_enable_bank_test.sv]
// self-checking bench of the peripheral interrupt enable bank
`timescale 1ns/1ps
`default_nettype none
module peripheral_interrupt_enable_bank_test;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        periph_irq;
  logic        irq;
  logic [23:0] set_ev = 24'h0;
  logic [23:0] clr_sw = 24'h0;
  logic [23:0] flags;
  logic [23:0] req;
  logic [23:0] pend;
  logic [7:0]  e1, e2, e3;
  logic [31:0] rd;
  logic        er;
  integer      n_errors = 0;
  integer      n_tests = 0;
  integer      b;
  always #2.5 sys_clk = ~sys_clk;
  periph_src_model u_src (.sys_clk(sys_clk), .set_ev(set_ev), .clr_sw(clr_sw), .flags(flags));
  periph_irq_enable u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_flags_one(flags[7:0]), .src_flags_two(flags[15:8]), .src_flags_three(flags[23:16]),
    .periph_req_one(req[7:0]), .periph_req_two(req[15:8]), .periph_req_three(req[23:16]),
    .periph_irq(periph_irq), .irq(irq));
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until ready is seen high at an edge; the bound catches a silent slave
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    integer i;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      test_done();
    end
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, exp, rd);
    chk("pslverr", {31'h0, eexp}, {31'h0, er});
  endtask
  task run(input logic [1:0] c, input logic [23:0] f);
    apb(1'b1, 12'h000, {24'h0, e1}, 4'hF);
    apb(1'b1, 12'h004, {24'h0, e2}, 4'hF);
    apb(1'b1, 12'h008, {24'h0, e3}, 4'hF);
    apb(1'b1, 12'h00C, {30'h0, c}, 4'hF);
    @(posedge sys_clk);
    set_ev <= f;
    clr_sw <= 24'hFFFFFF;
    @(posedge sys_clk);
    set_ev <= 24'h0;
    clr_sw <= 24'h0;
    repeat (4) @(posedge sys_clk);
    pend = f & {e3, e2, e1 & 8'h7F};
    rdc("pending", 12'h018, {8'h0, pend}, 1'b0);
    rdc("enable_one", 12'h000, {24'h0, e1 & 8'h7F}, 1'b0);
    rdc("enable_three", 12'h008, {24'h0, e3}, 1'b0);
    rdc("control", 12'h00C, {30'h0, c}, 1'b0);
    chk("req", (c != 2'h0) ? {8'h0, pend} : 32'h0, {8'h0, req});
    chk("periph_irq", {31'h0, c != 2'h0 && pend != 24'h0}, {31'h0, periph_irq});
  endtask
  initial begin
    void'($urandom(1062));
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (b = 0; b < 7; b++) rdc("reset value", 12'(b * 4), 32'h0, 1'b0);
    rdc("unmapped", 12'h01C, 32'h0, 1'b1);
    rdc("misaligned", 12'h002, 32'h0, 1'b1);
    apb(1'b1, 12'h000, 32'hFF, 4'hE);
    rdc("strobe off", 12'h000, 32'h0, 1'b0);
    e2 = 8'h00;
    e3 = 8'h00;
    for (b = 0; b < 8; b++) begin
      e1 = 8'(1 << b);
      run(2'h1, 24'hFFFFFF);
    end
    e1 = 8'hFF;
    e2 = 8'hFF;
    e3 = 8'hFF;
    for (b = 0; b < 4; b++) run(2'(b), 24'hFFFFFF);
    repeat (8) begin
      e1 = 8'($urandom);
      e2 = 8'($urandom);
      e3 = 8'($urandom);
      run(2'($urandom), 24'($urandom));
    end
    e1 = 8'h01;
    e2 = 8'h00;
    e3 = 8'h00;
    run(2'h1, 24'h0);
    apb(1'b0, 12'h010, 32'h0, 4'h0);
    apb(1'b1, 12'h014, 32'h1, 4'hF);
    run(2'h1, 24'h1);
    chk("irq", 32'h1, {31'h0, irq});
    rdc("status", 12'h010, 32'h1, 1'b0);
    rdc("status cleared", 12'h010, 32'h0, 1'b0);
    @(posedge sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h014, 32'h0, 4'hF);
    run(2'h1, 24'h0);
    run(2'h1, 24'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h014, 32'h1, 4'hF);
    @(posedge sys_clk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    rdc("mask", 12'h014, 32'h1, 1'b0);
    rdc("status masked", 12'h010, 32'h1, 1'b0);
    test_done();
  end
endmodule // peripheral_interrupt_enable_bank_test
bind periph_irq_enable periph_irq_enable_monitor u_mon (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .src_flags_one(src_flags_one), .periph_req_one(periph_req_one),
  .periph_req_two(periph_req_two), .periph_req_three(periph_req_three), .periph_irq(periph_irq));
`default_nettype wire
